// [core/burst_counter.sv]
// burst address counter with wrap mask, wrap flag and retransmit
`timescale 1ns/10ps
`default_nettype none
module burst_counter #(
    parameter int ADDR_W = dpram_pkg::ADDR_W_DEF
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic master_reset_async,
    input wire logic enabled,
    input wire logic load_addr,
    input wire logic count_en,
    input wire logic counter_reset,
    input wire logic mask_load,
    input wire logic retransmit_en,
    input wire logic [ADDR_W-1:0] addr_in,
    output logic [ADDR_W-1:0] access_addr,
    output logic [ADDR_W-1:0] count_value,
    output logic [ADDR_W-1:0] mask_value,
    output logic counter_wrap_flag
);
    import dpram_pkg::*;

    logic [ADDR_W-1:0] count_q; // internal counter
    logic [ADDR_W-1:0] count_d;
    logic [ADDR_W-1:0] mask_q; // bits allowed to advance
    logic [ADDR_W-1:0] mask_d;
    logic wrap_q; // sticky wrap flag
    logic wrap_d;
    logic at_end; // masked bits all ones
    logic wrap_event;

    // next address inside the masked block
    function automatic logic [ADDR_W-1:0] advance(input logic [ADDR_W-1:0] cur, input logic [ADDR_W-1:0] msk,
                                                input logic retx);
        logic [ADDR_W-1:0] inc;
        inc = ADDR_W'((cur & msk) + STEP);
        if ((cur & msk) == msk)
            advance = retx ? (cur & ~msk) : cur;
        else
            advance = (cur & ~msk) | (inc & msk);
    endfunction : advance

    // address used this cycle: loaded address or counter
    assign access_addr = load_addr ? addr_in : count_q;
    assign at_end = (access_addr & mask_q) == mask_q;
    assign wrap_event = enabled && count_en && at_end && (mask_q != '0);

    // next counter, mask and flag
    always_comb
    begin
        count_d = count_q;
        mask_d = mask_q;
        wrap_d = wrap_q;
        if (enabled)
        begin
            if (counter_reset)
                count_d = {ADDR_W{COUNT_RESET_BIT}};
            else if (count_en)
                count_d = advance(access_addr, mask_q, retransmit_en);
            else
                count_d = access_addr;
            if (mask_load)
                mask_d = addr_in;
            if (load_addr || counter_reset)
                wrap_d = FLAG_RESET;
            if (wrap_event)
                wrap_d = 1'b1;
        end
    end

    // state registers, master reset is asynchronous
    always_ff @(posedge ref_clk or posedge master_reset_async)
    begin
        if (master_reset_async)
        begin
            count_q <= {ADDR_W{COUNT_RESET_BIT}};
            mask_q <= {ADDR_W{MASK_RESET_BIT}};
            wrap_q <= FLAG_RESET;
        end
        else if (reset)
        begin
            count_q <= {ADDR_W{COUNT_RESET_BIT}};
            mask_q <= {ADDR_W{MASK_RESET_BIT}};
            wrap_q <= FLAG_RESET;
        end
        else
        begin
            count_q <= count_d;
            mask_q <= mask_d;
            wrap_q <= wrap_d;
        end
    end

    assign count_value = count_q;
    assign mask_value = mask_q;
    assign counter_wrap_flag = wrap_q;

    // wrap raises the flag one cycle later
    chk_wrap_flag_set: assert property (@(posedge ref_clk) disable iff (reset || master_reset_async)
        wrap_event && !counter_reset |=> counter_wrap_flag)
        else $error("wrap did not raise flag");

    // retransmit returns to block start
    chk_retransmit_start: assert property (@(posedge ref_clk) disable iff (reset || master_reset_async)
        wrap_event && retransmit_en && !counter_reset |=> count_value == $past(access_addr & ~mask_q))
        else $error("retransmit did not return to block start");
endmodule : burst_counter
`default_nettype wire

// [core/dpram_pkg.sv]
// shared constants for the dual-port memory and its address counters
package dpram_pkg;
    // word and lane layout
    localparam int DATA_W = 18;
    localparam int LANES = 2;
    localparam int LANE_W = 9;
    localparam int PORTS = 2;
    // default address width, 64K words (16, 17, 18 or 19 are legal)
    localparam int ADDR_W_DEF = 16;
    // port index of each side
    localparam int PORT_A = 0;
    localparam int PORT_B = 1;
    // reset values of counter state
    localparam logic COUNT_RESET_BIT = 1'b0;
    localparam logic MASK_RESET_BIT = 1'b1;
    localparam logic FLAG_RESET = 1'b0;
    // counter step
    localparam logic STEP = 1'b1;
    // per-port power state, one-hot
    typedef enum logic [1:0] {
        PWR_DOWN = 2'b01,
        PWR_ACTIVE = 2'b10
    } pwr_state_t;
endpackage : dpram_pkg

// [core/dual_port_ram.sv]
// synchronous dual-port 18-bit memory with burst counters, mailbox and collision flag
// Contract
// - two independent ports, any word, same cycle
// - read data registered, one stage later
// - address register holds advancing burst counter
// - internal write strobe self-timed, one cycle
// - chip enable inactive one cycle: power-down
// - enabled cycle needed before outputs drive
// - 18-bit words, 16 to 19 address bits
// - mask register limits which counter bits advance
// - wrap flag raised when counter wraps
// - counter value readable on address lines
// - mask value readable on address lines
// - mailbox flags signal between ports
// - asynchronous master reset clears both ports
// - byte lane enables gate reads, writes
// - busy raised on access collision
`timescale 1ns/10ps
`default_nettype none
module dual_port_ram #(
    parameter int ADDR_W = dpram_pkg::ADDR_W_DEF
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic master_reset_async,
    input wire logic [dpram_pkg::PORTS-1:0] chip_enable_active_low,
    input wire logic [dpram_pkg::PORTS-1:0] chip_enable_active_high,
    input wire logic [dpram_pkg::PORTS-1:0] read_not_write,
    input wire logic [dpram_pkg::PORTS-1:0][dpram_pkg::LANES-1:0] byte_lane_enables,
    input wire logic [dpram_pkg::PORTS-1:0] load_addr,
    input wire logic [dpram_pkg::PORTS-1:0] count_en,
    input wire logic [dpram_pkg::PORTS-1:0] counter_reset,
    input wire logic [dpram_pkg::PORTS-1:0] mask_load,
    input wire logic [dpram_pkg::PORTS-1:0] retransmit_en,
    input wire logic [dpram_pkg::PORTS-1:0] counter_readback,
    input wire logic [dpram_pkg::PORTS-1:0] mask_readback,
    input wire logic [dpram_pkg::PORTS-1:0][ADDR_W-1:0] addr_in,
    output logic [dpram_pkg::PORTS-1:0][ADDR_W-1:0] addr_out,
    output logic [dpram_pkg::PORTS-1:0] addr_oe,
    input wire logic [dpram_pkg::PORTS-1:0][dpram_pkg::DATA_W-1:0] data_in,
    output logic [dpram_pkg::PORTS-1:0][dpram_pkg::DATA_W-1:0] data_out,
    output logic [dpram_pkg::PORTS-1:0][dpram_pkg::LANES-1:0] data_oe,
    output logic [dpram_pkg::PORTS-1:0] counter_wrap_flag,
    output logic [dpram_pkg::PORTS-1:0] busy,
    output logic [dpram_pkg::PORTS-1:0] powered_down,
    input wire logic [dpram_pkg::PORTS-1:0] mailbox_set,
    input wire logic [dpram_pkg::PORTS-1:0] mailbox_clear,
    output logic [dpram_pkg::PORTS-1:0] mailbox_flag
);
    import dpram_pkg::*;

    localparam int DEPTH = 1 << ADDR_W; // words in the array

    // storage shared by both ports
    logic [DATA_W-1:0] mem [DEPTH];

    // per-port decoded controls
    logic [PORTS-1:0] enabled; // both chip enables asserted
    logic [PORTS-1:0][ADDR_W-1:0] access_addr; // address of this cycle
    logic [PORTS-1:0][ADDR_W-1:0] count_value;
    logic [PORTS-1:0][ADDR_W-1:0] mask_value;
    logic [PORTS-1:0][LANES-1:0] wr_lane; // internal write strobes
    logic [PORTS-1:0][LANES-1:0] rd_lane; // lanes read this cycle
    logic [PORTS-1:0] is_write; // any write this cycle

    // output and status registers
    pwr_state_t [PORTS-1:0] pwr_q;
    pwr_state_t [PORTS-1:0] pwr_d;
    logic [PORTS-1:0][LANES-1:0] oe_q;
    logic [PORTS-1:0][LANES-1:0] oe_d;
    logic [PORTS-1:0][ADDR_W-1:0] rb_q; // readback value
    logic [PORTS-1:0][ADDR_W-1:0] rb_d;
    logic [PORTS-1:0] rb_oe_q;
    logic [PORTS-1:0] rb_oe_d;
    logic [PORTS-1:0] busy_q;
    logic [PORTS-1:0] busy_d;
    logic [PORTS-1:0] mbox_q;
    logic [PORTS-1:0] mbox_d;
    logic [PORTS-1:0][DATA_W-1:0] rdata_q; // output data register
    logic collision; // both ports on one word, one writing

    // both enables asserted means the port is selected
    function automatic logic port_selected(input logic ce_low, input logic ce_high);
        port_selected = !ce_low && ce_high;
    endfunction : port_selected

    // other port index
    function automatic int other(input int p);
        other = (p == PORT_A) ? PORT_B : PORT_A;
    endfunction : other

    // lane enables widened to a mask over the word
    function automatic logic [DATA_W-1:0] lane_bits(input logic [LANES-1:0] lanes);
        for (int k = 0; k < LANES; k++)
            lane_bits[k*LANE_W +: LANE_W] = {LANE_W{lanes[k]}};
    endfunction : lane_bits

    genvar p;
    genvar l;
    generate
        for (p = 0; p < PORTS; p++)
        begin : g_port
            // chip enable decode, power-down when either inactive
            assign enabled[p] = port_selected(chip_enable_active_low[p], chip_enable_active_high[p]);
            assign is_write[p] = enabled[p] && !read_not_write[p];

            // burst counter and mask for this port
            burst_counter #(
                .ADDR_W(ADDR_W)
            ) burst_counter_i (
                .ref_clk(ref_clk),
                .reset(reset),
                .master_reset_async(master_reset_async),
                .enabled(enabled[p]),
                .load_addr(load_addr[p]),
                .count_en(count_en[p]),
                .counter_reset(counter_reset[p]),
                .mask_load(mask_load[p]),
                .retransmit_en(retransmit_en[p]),
                .addr_in(addr_in[p]),
                .access_addr(access_addr[p]),
                .count_value(count_value[p]),
                .mask_value(mask_value[p]),
                .counter_wrap_flag(counter_wrap_flag[p])
            );

            for (l = 0; l < LANES; l++)
            begin : g_lane
                // one strobe per sampled write cycle, lane gated
                assign wr_lane[p][l] = is_write[p] && byte_lane_enables[p][l];
                assign rd_lane[p][l] = enabled[p] && read_not_write[p] && byte_lane_enables[p][l];
            end

            // next power state, output enables and readback
            always_comb
            begin
                pwr_d[p] = enabled[p] ? PWR_ACTIVE : PWR_DOWN;
                oe_d[p] = oe_q[p];
                rb_oe_d[p] = 1'b0;
                rb_d[p] = rb_q[p];
                if (!enabled[p])
                    oe_d[p] = '0;
                else if (read_not_write[p])
                    oe_d[p] = byte_lane_enables[p];
                else
                    oe_d[p] = '0;
                if (enabled[p] && counter_readback[p])
                begin
                    rb_d[p] = count_value[p];
                    rb_oe_d[p] = 1'b1;
                end
                else if (enabled[p] && mask_readback[p])
                begin
                    rb_d[p] = mask_value[p];
                    rb_oe_d[p] = 1'b1;
                end
            end

            // collision shows on both ports
            assign busy_d[p] = collision;

            // mailbox: other port sets, own port clears, set wins
            always_comb
            begin
                mbox_d[p] = mbox_q[p];
                if (mailbox_clear[p])
                    mbox_d[p] = 1'b0;
                if (mailbox_set[other(p)])
                    mbox_d[p] = 1'b1;
            end

            // read launches its lanes one cycle after request, other lanes held
            chk_read_pipeline: assert property (@(posedge ref_clk) disable iff (reset || master_reset_async)
                rd_lane[p] != '0 |=> data_oe[p] == $past(rd_lane[p])
                && ((data_out[p] ^ $past(mem[access_addr[p]])) & lane_bits($past(rd_lane[p]))) == '0)
                else $error("read data not one stage later");

            // deselection drops outputs next cycle
            chk_power_down: assert property (@(posedge ref_clk) disable iff (reset || master_reset_async)
                !enabled[p] |=> data_oe[p] == '0 && powered_down[p])
                else $error("port did not power down");

            // after power-down, outputs wait for an enabled cycle
            chk_wake_cycle: assert property (@(posedge ref_clk) disable iff (reset || master_reset_async)
                powered_down[p] && !enabled[p] |=> data_oe[p] == '0)
                else $error("outputs driven without enabled cycle");

            // write with lane enable stores data next cycle
            chk_write_store: assert property (@(posedge ref_clk) disable iff (reset || master_reset_async)
                wr_lane[p][0] && !is_write[other(p)]
                |=> mem[$past(access_addr[p])][LANE_W-1:0] == $past(data_in[p][LANE_W-1:0]))
                else $error("write not stored");

            // counter readback drives address lines
            chk_count_readback: assert property (@(posedge ref_clk) disable iff (reset || master_reset_async)
                enabled[p] && counter_readback[p] |=> addr_oe[p] && addr_out[p] == $past(count_value[p]))
                else $error("counter readback wrong");

            // mailbox set reaches other port
            chk_mailbox_set: assert property (@(posedge ref_clk) disable iff (reset || master_reset_async)
                mailbox_set[p] |=> mailbox_flag[other(p)])
                else $error("mailbox flag not raised");

            // collision flags busy next cycle
            chk_busy_flag: assert property (@(posedge ref_clk) disable iff (reset || master_reset_async)
                collision |=> busy[p])
                else $error("busy not raised on collision");

            // master reset clears outputs regardless of clock
            chk_master_reset: assert property (@(posedge ref_clk)
                master_reset_async |-> data_oe[p] == '0 && !mailbox_flag[p] && !counter_wrap_flag[p])
                else $error("master reset did not clear port");

            // mask readback drives address lines
            chk_mask_readback: assert property (@(posedge ref_clk) disable iff (reset || master_reset_async)
                enabled[p] && mask_readback[p] && !counter_readback[p]
                |=> addr_oe[p] && addr_out[p] == $past(mask_value[p]))
                else $error("mask readback wrong");

            // address lines released without a readback request
            chk_readback_idle: assert property (@(posedge ref_clk) disable iff (reset || master_reset_async)
                !(enabled[p] && (counter_readback[p] || mask_readback[p])) |=> !addr_oe[p])
                else $error("address lines driven without request");

            // data lines driven only after a selected read
            chk_read_only_drive: assert property (@(posedge ref_clk) disable iff (reset || master_reset_async)
                !(enabled[p] && read_not_write[p]) |=> data_oe[p] == '0)
                else $error("data lines driven without read");

            // busy lasts one cycle per collision
            chk_busy_clear: assert property (@(posedge ref_clk) disable iff (reset || master_reset_async)
                !collision |=> !busy[p])
                else $error("busy without collision");

            // own clear drops the flag unless the other port sets it at once
            chk_mailbox_clear: assert property (@(posedge ref_clk) disable iff (reset || master_reset_async)
                mailbox_clear[p] && !mailbox_set[other(p)] |=> !mailbox_flag[p])
                else $error("mailbox flag not cleared");
        end
    endgenerate

    // same word on both ports with at least one write
    assign collision = enabled[PORT_A] && enabled[PORT_B] && (access_addr[PORT_A] == access_addr[PORT_B])
                       && (is_write[PORT_A] || is_write[PORT_B]);

    // array access, both ports in the same cycle
    always_ff @(posedge ref_clk)
    begin
        for (int i = 0; i < PORTS; i++)
        begin
            for (int j = 0; j < LANES; j++)
            begin
                // same-word double write: port B is written last and its data wins
                if (wr_lane[i][j])
                    mem[access_addr[i]][j*LANE_W +: LANE_W] <= data_in[i][j*LANE_W +: LANE_W];
                if (rd_lane[i][j])
                    rdata_q[i][j*LANE_W +: LANE_W] <= mem[access_addr[i]][j*LANE_W +: LANE_W];
            end
        end
    end

    // port control registers, master reset is asynchronous
    always_ff @(posedge ref_clk or posedge master_reset_async)
    begin
        if (master_reset_async)
        begin
            for (int i = 0; i < PORTS; i++)
                pwr_q[i] <= PWR_DOWN;
            oe_q <= '0;
            rb_q <= '0;
            rb_oe_q <= '0;
            busy_q <= '0;
            mbox_q <= '0;
        end
        else if (reset)
        begin
            for (int i = 0; i < PORTS; i++)
                pwr_q[i] <= PWR_DOWN;
            oe_q <= '0;
            rb_q <= '0;
            rb_oe_q <= '0;
            busy_q <= '0;
            mbox_q <= '0;
        end
        else
        begin
            pwr_q <= pwr_d;
            oe_q <= oe_d;
            rb_q <= rb_d;
            rb_oe_q <= rb_oe_d;
            busy_q <= busy_d;
            mbox_q <= mbox_d;
        end
    end

    // registered outputs
    assign data_out = rdata_q;
    assign data_oe = oe_q;
    assign addr_out = rb_q;
    assign addr_oe = rb_oe_q;
    assign busy = busy_q;
    assign mailbox_flag = mbox_q;

    // power state shown per port
    always_comb
    begin
        for (int i = 0; i < PORTS; i++)
            powered_down[i] = (pwr_q[i] == PWR_DOWN);
    end
endmodule : dual_port_ram
`default_nettype wire

// [test/port_host.sv]
// host model that drives one memory port, one request per clock
`timescale 1ns/10ps
`default_nettype none
module port_host #(
    parameter int W = 8
) (
    input wire logic ref_clk,
    output logic ce_n,
    output logic ce,
    output logic rnw,
    output logic [1:0] bel,
    output logic [8:0] ctl,
    output logic [W-1:0] addr,
    output logic [dpram_pkg::DATA_W-1:0] din
);
    import dpram_pkg::*;
    // deselected and quiet from time zero
    initial
    begin
        ce_n = 1'b1;
        ce = 1'b0;
        rnw = 1'b1;
        bel = 2'b00;
        ctl = 9'h000;
        addr = '0;
        din = 18'h00000;
    end
    // one selected cycle; f = {rnw, lanes[1:0], mclr, mset, retx, mread, cread, mload, crst, cnt, load}
    task cyc(input logic [11:0] f, input logic [W-1:0] a, input logic [17:0] d);
        @(posedge ref_clk);
        ce_n <= 1'b0;
        ce <= 1'b1;
        rnw <= f[11];
        bel <= f[10:9];
        ctl <= f[8:0];
        addr <= a;
        din <= d;
    endtask : cyc
    // deselect cycle; released lines show the inverse of their last value
    task idle(input logic [1:0] en = 2'b10);
        @(posedge ref_clk);
        {ce_n, ce} <= en;
        ctl <= 9'h000;
        addr <= ~addr;
        din <= ~din;
    endtask : idle
endmodule : port_host
`default_nettype wire

// [test/sync_dual_port_ram_ports_tb.sv]
// self-checking bench for the dual-port memory with two host models
`timescale 1ns/10ps
`default_nettype none
module sync_dual_port_ram_ports_tb;
    import dpram_pkg::*;
    localparam int AW = 8;
    // request flag codes for the host model
    localparam logic [11:0] LD = 12'h001;
    localparam logic [11:0] CN = 12'h002;
    localparam logic [11:0] CR = 12'h004;
    localparam logic [11:0] ML = 12'h008;
    localparam logic [11:0] RC = 12'h010;
    localparam logic [11:0] RM = 12'h020;
    localparam logic [11:0] RT = 12'h040;
    localparam logic [11:0] MS = 12'h080;
    localparam logic [11:0] MC = 12'h100;
    localparam logic [11:0] B01 = 12'h200;
    localparam logic [11:0] B11 = 12'h600;
    localparam logic [11:0] RD = 12'h800;
    logic ref_clk;
    logic reset;
    logic master_reset_async;
    int fails;
    int n_tests;
    // host side nets
    wire logic [1:0] ce_n;
    wire logic [1:0] ce;
    wire logic [1:0] rnw;
    wire logic [1:0][1:0] bel;
    wire logic [1:0][8:0] ctl;
    wire logic [1:0][AW-1:0] ain;
    wire logic [1:0][DATA_W-1:0] din;
    // memory outputs
    wire logic [1:0][AW-1:0] addr_out;
    wire logic [1:0] addr_oe;
    wire logic [1:0][DATA_W-1:0] data_out;
    wire logic [1:0][1:0] data_oe;
    wire logic [1:0] wrap;
    wire logic [1:0] busy;
    wire logic [1:0] pdn;
    wire logic [1:0] mbox;
    port_host #(.W(AW)) host_a (.ref_clk(ref_clk), .ce_n(ce_n[0]), .ce(ce[0]), .rnw(rnw[0]), .bel(bel[0]),
        .ctl(ctl[0]), .addr(ain[0]), .din(din[0]));
    port_host #(.W(AW)) host_b (.ref_clk(ref_clk), .ce_n(ce_n[1]), .ce(ce[1]), .rnw(rnw[1]), .bel(bel[1]),
        .ctl(ctl[1]), .addr(ain[1]), .din(din[1]));
    dual_port_ram #(.ADDR_W(AW)) dual_port_ram_i (
        .ref_clk(ref_clk),
        .reset(reset),
        .master_reset_async(master_reset_async),
        .chip_enable_active_low(ce_n),
        .chip_enable_active_high(ce),
        .read_not_write(rnw),
        .byte_lane_enables(bel),
        .load_addr({ctl[1][0], ctl[0][0]}),
        .count_en({ctl[1][1], ctl[0][1]}),
        .counter_reset({ctl[1][2], ctl[0][2]}),
        .mask_load({ctl[1][3], ctl[0][3]}),
        .counter_readback({ctl[1][4], ctl[0][4]}),
        .mask_readback({ctl[1][5], ctl[0][5]}),
        .retransmit_en({ctl[1][6], ctl[0][6]}),
        .mailbox_set({ctl[1][7], ctl[0][7]}),
        .mailbox_clear({ctl[1][8], ctl[0][8]}),
        .addr_in(ain),
        .addr_out(addr_out),
        .addr_oe(addr_oe),
        .data_in(din),
        .data_out(data_out),
        .data_oe(data_oe),
        .counter_wrap_flag(wrap),
        .busy(busy),
        .powered_down(pdn),
        .mailbox_flag(mbox)
    );
    // 50 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // compare and count
    task chk(input logic [17:0] got, input logic [17:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // counts, verdict, end of run
    task summarize;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize
    // reset values seen at the ports
    task t_reset;
        #1 chk(pdn, 2'b11);
        chk(data_oe, 4'h0);
        chk(addr_oe, 2'b00);
        chk(mbox, 2'b00);
        chk(wrap, 2'b00);
        chk(busy, 2'b00);
    endtask : t_reset
    // simultaneous writes, lane write, simultaneous reads
    task t_rw;
        fork
            host_a.cyc(B11 | LD, 8'h10, 18'h2a5a5);
            host_b.cyc(B11 | LD, 8'h20, 18'h15a5a);
        join
        host_a.cyc(B01 | LD, 8'h10, 18'h3ffff);
        #1 chk(busy, 2'b00);
        fork
            host_a.cyc(RD | B11 | LD, 8'h20, 18'h00000);
            host_b.cyc(RD | B11 | LD, 8'h10, 18'h00000);
        join
        fork
            host_a.cyc(RD | B01 | LD, 8'h10, 18'h00000);
            host_b.idle();
        join
        #1 chk(data_out[0], 18'h15a5a);
        chk(data_out[1], 18'h2a5ff);
        chk(data_oe, 4'hf);
        host_a.idle();
        #1 chk(data_out[0], 18'h15bff);
        chk(data_oe, 4'h1);
        chk(pdn, 2'b10);
    endtask : t_rw
    // either enable alone powers down, one enabled cycle wakes
    task t_pwr;
        for (int k = 0; k < 2; k++)
        begin
            host_a.cyc(RD | B11 | LD, 8'h20, 18'h00000);
            host_a.idle(k ? 2'b00 : 2'b11);
            #1 chk(data_oe[0], 2'b11);
            chk(pdn[0], 1'b0);
            host_a.idle();
            #1 chk(data_oe[0], 2'b00);
            chk(pdn[0], 1'b1);
        end
    endtask : t_pwr
    // held write burst then read burst from the counter
    task t_burst;
        for (int i = 0; i < 4; i++)
            host_a.cyc(B11 | (i ? CN : LD | CN), 8'h40, 18'h20000 | 18'(i));
        for (int i = 0; i < 5; i++)
        begin
            if (i < 4)
                host_a.cyc(RD | B11 | (i ? CN : LD | CN), 8'h40, 18'h00000);
            else
                host_a.idle();
            #1 if (i > 0) chk(data_out[0], 18'h20000 | 18'(i - 1));
        end
    endtask : t_burst
    // mask, wrap flag, readbacks, hold and retransmit
    task t_wrap;
        host_b.cyc(RM, 8'h00, 18'h00000);
        host_b.idle();
        #1 chk(addr_out[1], 8'hff);
        host_b.cyc(ML, 8'h03, 18'h00000);
        for (int r = 0; r < 2; r++)
        begin
            host_b.cyc(LD | CN | (r ? RT : 12'h000), 8'h24, 18'h00000);
            host_b.idle();
            #1 chk(wrap[1], 1'b0);
            repeat (3) host_b.cyc(CN | (r ? RT : 12'h000), 8'h24, 18'h00000);
            host_b.idle();
            host_b.idle();
            #1 chk(wrap[1], 1'b1);
            host_b.cyc(RC, 8'h00, 18'h00000);
            host_b.idle();
            #1 chk(addr_out[1], r ? 8'h24 : 8'h27);
            chk(addr_oe[1], 1'b1);
            host_b.idle();
            #1 chk(addr_oe[1], 1'b0);
        end
        host_b.cyc(CR, 8'h00, 18'h00000);
        host_b.idle();
        #1 chk(wrap[1], 1'b0);
        host_b.cyc(RC, 8'h00, 18'h00000);
        host_b.idle();
        #1 chk(addr_out[1], 8'h00);
    endtask : t_wrap
    // read and write to one word in one cycle
    task t_busy;
        fork
            host_a.cyc(RD | B11 | LD, 8'h10, 18'h00000);
            host_b.cyc(B11 | LD, 8'h10, 18'h0abcd);
        join
        fork
            host_a.idle();
            host_b.idle();
        join
        #1 chk(busy, 2'b11);
        host_a.idle();
        #1 chk(busy, 2'b00);
    endtask : t_busy
    // mailbox set and clear across ports
    task t_mbox;
        host_a.cyc(MS, 8'h00, 18'h00000);
        host_a.idle();
        #1 chk(mbox, 2'b10);
        host_b.cyc(MC | MS, 8'h00, 18'h00000);
        host_b.idle();
        #1 chk(mbox, 2'b01);
        fork
            host_a.cyc(MS, 8'h00, 18'h00000);
            host_b.cyc(MC, 8'h00, 18'h00000);
        join
        fork
            host_a.idle();
            host_b.idle();
        join
        #1 chk(mbox, 2'b11);
    endtask : t_mbox
    // master reset held across a clock edge, memory kept
    task t_mreset;
        host_a.idle();
        #5 master_reset_async = 1'b1;
        #2 chk(mbox, 2'b00);
        chk(wrap, 2'b00);
        chk(pdn, 2'b11);
        #20 master_reset_async = 1'b0;
        host_a.cyc(RD | B11 | LD, 8'h20, 18'h00000);
        host_a.idle();
        #1 chk(data_out[0], 18'h15a5a);
    endtask : t_mreset
    // main sequence
    initial
    begin
        fails = 0;
        n_tests = 0;
        reset = 1'b1;
        master_reset_async = 1'b0;
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        t_reset();
        t_rw();
        t_pwr();
        t_burst();
        t_wrap();
        t_busy();
        t_mbox();
        t_mreset();
        summarize();
    end
    // watchdog, about 28 times the expected run
    initial
    begin
        #40000;
        fails++;
        summarize();
    end
endmodule : sync_dual_port_ram_ports_tb
`default_nettype wire
